/* File: src/pctc_defines.svh */
// Register offsets, field positions, reset values and timing counts
// for the parallel capture transfer control block.
// Assumes byte addresses on a 32-bit Avalon-MM slave, one word each.
`ifndef PCTC_DEFINES_SVH
`define PCTC_DEFINES_SVH
// Byte offsets
`define PCTC_OFS_TRMCTL 8'h00
`define PCTC_OFS_SPMOD 8'h04
`define PCTC_OFS_CAPCTL 8'h08
`define PCTC_OFS_EVCNT 8'h0C
`define PCTC_OFS_RLD0 8'h10
`define PCTC_OFS_RLD1 8'h14
`define PCTC_OFS_ADR0 8'h18
`define PCTC_OFS_ADR1 8'h1C
`define PCTC_OFS_TRCNT 8'h20
// transfer_control fields
`define PCTC_TC_SWEV 7
`define PCTC_TC_SEL_HI 5
`define PCTC_TC_SEL_LO 4
`define PCTC_TC_MODE 3
`define PCTC_TC_ACT 2
`define PCTC_TC_BUF 1
`define PCTC_TC_SRST 0
// special_mode_control fields
`define PCTC_SP_CSEL_HI 7
`define PCTC_SP_CSEL_LO 6
`define PCTC_SP_EN 3
`define PCTC_SP_ISL 2
`define PCTC_SP_RSM 1
`define PCTC_SP_SSL 0
// capture control fields
`define PCTC_CC_EVSEL_HI 9
`define PCTC_CC_EVSEL_LO 8
`define PCTC_CC_WID_HI 7
`define PCTC_CC_WID_LO 6
`define PCTC_CC_EN 0
// Reset values
`define PCTC_RST_8 8'h00
`define PCTC_RST_32 32'h00000000
// Timing counts in acquisition clock periods
`define PCTC_SRST_DLY 4
`define PCTC_INIT_DLY 4
// Buffer depth
`define PCTC_BUF_DEPTH 4
`endif

/* File: src/pctc_pkg.sv */
// Types shared by the parallel capture transfer control block.
// Assumes pctc_defines.svh holds the numbers.
package pctc_pkg;
	// Address counter selection codes
	typedef enum logic [1:0] {
		PCTC_SEL_C0 = 2'h0,
		PCTC_SEL_C1 = 2'h1,
		PCTC_SEL_ALT = 2'h2
	} pctc_adsel_e;
	// Input width codes
	typedef enum logic [1:0] {
		PCTC_W8 = 2'h0,
		PCTC_W16 = 2'h1,
		PCTC_W32 = 2'h2
	} pctc_width_e;
	// One buffered word
	typedef struct packed {
		logic last;
		logic [31:0] data;
	} pctc_ent_s;
	// Write request toward the destination RAM
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} pctc_ramwr_s;
endpackage

/* File: src/pctc_top.sv */
// Transfer control and special mode front end of a parallel capture unit.
// Assumes pins are asynchronous to clk and the acquisition clock is slow
// enough (several clk periods per phase) to be sampled and edge detected.
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pctc_defines.svh"
// Operation
// - Continuous mode: active counter plus 4, no reload
// - Reload mode: load on enable rise, plus 4
// - One mode bit for both counters
// - Word per 4/2/1 events by width
// - Last event flushes word, zero padded
// - Read-only active counter status bit
// - Four-deep word buffer, occupancy status bit
// - Soft reset low: no capture, no transfers
// - Reset clear cancels pending transfers, stops capture
// - Reset clear zeroes status, counter, selection
// - Pin processing runs regardless of soft reset
// - Soft reset set acts after 4 periods, clear after 1
// - Status bits initialize within one period
// - Special mode halves rate, 8/16 bits
// - Special clock pin select three/four/two
// - Init level forces outputs low, no capture
// - Init direct or 4 periods delayed
module pctc_top (
	input wire logic clk, // 25 MHz system clock
	input wire logic rst, // Async reset, active high
	input wire logic [7:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire logic acquisition_clock, // Acquisition clock pin
	input wire logic first_control_pin, // Init control pin
	input wire logic [5:2] strobe_pins, // Strobe pins two to five
	input wire logic [31:0] data_pins, // Parallel data pins
	input wire logic dec4_underflow, // Decimation counter four event
	output pctc_pkg::pctc_ramwr_s ram_wr, // RAM write address and data
	output logic ram_valid, // RAM write request
	input wire logic ram_ready // RAM accepts write
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and acquisition clock edge
	logic [37:0] sync1_r; // First stage, read only by second
	logic [37:0] sync2_r; // Second stage
	logic acq_prev_r; // Previous synced acquisition clock
	wire s_acq = sync2_r[37];
	wire s_pin1 = sync2_r[36];
	wire [3:0] s_strb = sync2_r[35:32];
	wire [31:0] s_data = sync2_r[31:0];
	wire acq_tick = s_acq & ~acq_prev_r;

	// Two flops on every pin, none bypassed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 38'h0;
			sync2_r <= 38'h0;
			acq_prev_r <= 1'b0;
		end else begin
			sync1_r <= {acquisition_clock, first_control_pin, strobe_pins,
				data_pins};
			sync2_r <= sync1_r;
			acq_prev_r <= s_acq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers
	logic [7:0] tc_r; // transfer_control writable bits
	logic [7:0] sp_r; // special_mode_control
	logic cap_en_r; // capture_enable
	logic [1:0] width_r; // input_width_select
	logic [1:0] evsel_r; // capture_event_select
	logic [31:0] evcnt_r; // capture_event_count_setting
	logic [31:0] rld0_r; // Reload value for counter zero
	logic [31:0] rld1_r; // Reload value for counter one
	logic ack_r; // Bus answer phase
	wire req = avs_read | avs_write;
	wire wr_go = avs_write & ack_r;
	wire w_tc = wr_go & (avs_address == `PCTC_OFS_TRMCTL);
	wire w_sp = wr_go & (avs_address == `PCTC_OFS_SPMOD);
	wire w_cc = wr_go & (avs_address == `PCTC_OFS_CAPCTL);
	wire w_ev = wr_go & (avs_address == `PCTC_OFS_EVCNT);
	wire w_r0 = wr_go & (avs_address == `PCTC_OFS_RLD0);
	wire w_r1 = wr_go & (avs_address == `PCTC_OFS_RLD1);
	wire w_a0 = wr_go & (avs_address == `PCTC_OFS_ADR0);
	wire w_a1 = wr_go & (avs_address == `PCTC_OFS_ADR1);
	wire be0 = avs_byteenable[0];
	wire be1 = avs_byteenable[1];
	wire addr_counter_mode = tc_r[`PCTC_TC_MODE];
	wire counter_switch_event = tc_r[`PCTC_TC_SWEV];
	wire [1:0] addr_counter_select = tc_r[`PCTC_TC_SEL_HI:`PCTC_TC_SEL_LO];
	wire unit_soft_reset = tc_r[`PCTC_TC_SRST];
	wire special_mode_enable = sp_r[`PCTC_SP_EN];
	wire [1:0] spsel = sp_r[`PCTC_SP_CSEL_HI:`PCTC_SP_CSEL_LO];
	wire special_init_level_select = sp_r[`PCTC_SP_ISL];
	wire special_init_method = sp_r[`PCTC_SP_RSM];

	// Merge a write under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// One wait cycle per access; write lands at the answer edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end
	assign avs_waitrequest = req & ~ack_r;

	////////////////////////////////////////////////////////////////////////
	// Soft reset timing and special mode init, on acquisition ticks
	logic [3:0] srst_sh_r; // Soft reset value delayed by ticks
	logic [3:0] init_sh_r; // Init level delayed by ticks
	// Takes effect after the full delay; stops at once on the first tick
	wire run = srst_sh_r[`PCTC_SRST_DLY-1] & srst_sh_r[0];
	wire st_clr = ~srst_sh_r[0];
	wire init_lvl = (s_pin1 == special_init_level_select);
	wire sp_init = special_mode_enable & (special_init_method ?
		init_sh_r[`PCTC_INIT_DLY-1] : init_lvl);

	// Shift registers clocked by the sampled acquisition clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			srst_sh_r <= 4'h0;
			init_sh_r <= 4'h0;
		end else if (acq_tick) begin
			srst_sh_r <= {srst_sh_r[2:0], unit_soft_reset};
			init_sh_r <= {init_sh_r[2:0], init_lvl};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event detection and special mode divider; never gated by soft reset
	logic [3:0] strb_q_r; // Strobes at previous tick
	logic div_r; // Half-rate special mode signal
	logic div_q_r; // Divider at previous tick
	// 00 pin three, 01 pin four, 10 pin two; 11 falls back to pin two
	wire sp_pin = (spsel == 2'h0) ? s_strb[1] :
		(spsel == 2'h1) ? s_strb[2] : s_strb[0];
	wire sp_pin_q = (spsel == 2'h0) ? strb_q_r[1] :
		(spsel == 2'h1) ? strb_q_r[2] : strb_q_r[0];
	wire sp_fall = acq_tick & sp_pin_q & ~sp_pin;
	wire sp_out = div_r & ~sp_init;
	wire [3:0] raw_evt = {4{acq_tick}} & s_strb & ~strb_q_r;
	wire sp_evt = acq_tick & sp_out & ~div_q_r;
	wire sel_evt = special_mode_enable ? sp_evt : raw_evt[evsel_r];

	// Divider toggles once per falling edge, so events come at half rate
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strb_q_r <= 4'h0;
			div_r <= 1'b0;
			div_q_r <= 1'b0;
		end else begin
			if (acq_tick) begin
				strb_q_r <= s_strb;
				div_q_r <= sp_out;
			end
			if (~special_mode_enable | sp_init) begin
				div_r <= 1'b0;
			end else if (sp_fall) begin
				div_r <= ~div_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Word packing
	logic [1:0] lane_r; // Next lane within word
	logic [31:0] acc_r; // Partly filled word
	logic [31:0] remain_r; // Events left, zero means unlimited
	logic cap_en_q_r; // capture_enable of previous cycle
	wire cap_evt = run & cap_en_r & sel_evt & ~sp_init;
	wire cap_rise = cap_en_r & ~cap_en_q_r;
	wire last_evt = (remain_r == 32'h1);
	wire [1:0] lane_max = (width_r == pctc_pkg::PCTC_W8) ? 2'h3 :
		(width_r == pctc_pkg::PCTC_W16) ? 2'h1 : 2'h0;
	wire [31:0] d8 = {24'h0, s_data[7:0]} << {lane_r, 3'h0};
	wire [31:0] d16 = {16'h0, s_data[15:0]} << {lane_r[0], 4'h0};
	wire [31:0] dlane = (width_r == pctc_pkg::PCTC_W8) ? d8 :
		(width_r == pctc_pkg::PCTC_W16) ? d16 : s_data;
	wire [31:0] word = acc_r | dlane; // Unfilled lanes stay zero
	wire push = cap_evt & ((lane_r == lane_max) | last_evt);

	// Accumulate lanes low first; cleared by soft reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lane_r <= 2'h0;
			acc_r <= `PCTC_RST_32;
			cap_en_q_r <= 1'b0;
		end else begin
			cap_en_q_r <= cap_en_r;
			if (st_clr | cap_rise | push) begin
				lane_r <= 2'h0;
				acc_r <= `PCTC_RST_32;
			end else if (cap_evt) begin
				lane_r <= lane_r + 2'h1;
				acc_r <= word;
			end
		end
	end

	// Event count loads on enable rise, counts down per event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remain_r <= `PCTC_RST_32;
		end else if (cap_rise) begin
			remain_r <= evcnt_r;
		end else if (cap_evt & (remain_r != 32'h0)) begin
			remain_r <= remain_r - 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Four-deep intermediate buffer
	pctc_pkg::pctc_ent_s buf_r [`PCTC_BUF_DEPTH]; // Stored words
	logic [1:0] wp_r; // Write index
	logic [1:0] rp_r; // Read index
	logic [2:0] cnt_r; // Occupancy
	wire buf_full = (cnt_r == 3'(`PCTC_BUF_DEPTH));
	wire buf_nempty = (cnt_r != 3'h0);
	// Overrun drops the new word rather than the oldest
	wire do_push = push & ~buf_full;
	wire do_pop = ram_valid & ram_ready;
	pctc_pkg::pctc_ent_s head;
	assign head = buf_r[rp_r];
	assign ram_valid = buf_nempty & run;

	// Storage written only on push
	always_ff @(posedge clk) begin
		if (do_push) begin
			buf_r[wp_r] <= '{last: last_evt, data: word};
		end
	end

	// Pointers; soft reset clear empties the buffer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r <= 2'h0;
			rp_r <= 2'h0;
			cnt_r <= 3'h0;
		end else if (st_clr) begin
			wp_r <= 2'h0;
			rp_r <= 2'h0;
			cnt_r <= 3'h0;
		end else begin
			wp_r <= wp_r + {1'b0, do_push};
			rp_r <= rp_r + {1'b0, do_pop};
			cnt_r <= cnt_r + {2'h0, do_push} - {2'h0, do_pop};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Destination address counters and transfer counter
	logic [31:0] adr0_r; // dest_address_counter_zero
	logic [31:0] adr1_r; // dest_address_counter_one
	logic alt_r; // Active counter under alternation
	logic [31:0] trcnt_r; // transfer_counter, completed words
	wire alt_mode = (addr_counter_select == pctc_pkg::PCTC_SEL_ALT);
	wire act = alt_mode ? alt_r :
		(addr_counter_select == pctc_pkg::PCTC_SEL_C1);
	wire sw_evt = counter_switch_event ? dec4_underflow :
		(do_pop & head.last);
	wire reload = addr_counter_mode & cap_rise;

	// Counter advance; the reload value is used only in reload mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			adr0_r <= `PCTC_RST_32;
			adr1_r <= `PCTC_RST_32;
		end else if (reload) begin
			adr0_r <= rld0_r;
			adr1_r <= rld1_r;
		end else begin
			if (w_a0) begin
				adr0_r <= be_merge(adr0_r, avs_writedata, avs_byteenable);
			end else if (do_pop & ~act) begin
				adr0_r <= adr0_r + 32'h4;
			end
			if (w_a1) begin
				adr1_r <= be_merge(adr1_r, avs_writedata, avs_byteenable);
			end else if (do_pop & act) begin
				adr1_r <= adr1_r + 32'h4;
			end
		end
	end

	// Alternation and transfer count, both reset by soft reset clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alt_r <= 1'b0;
			trcnt_r <= `PCTC_RST_32;
		end else if (st_clr) begin
			alt_r <= 1'b0;
			trcnt_r <= `PCTC_RST_32;
		end else begin
			if (alt_mode & sw_evt & run) begin
				alt_r <= ~alt_r;
			end
			if (do_pop) begin
				trcnt_r <= trcnt_r + 32'h1;
			end
		end
	end

	// RAM write outputs held in flops beside the buffer head
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ram_wr <= '0;
		end else begin
			ram_wr.addr <= act ? adr1_r : adr0_r;
			ram_wr.data <= head.data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register writes
	// Software must leave mode and selection alone while running
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tc_r <= `PCTC_RST_8;
			sp_r <= `PCTC_RST_8;
			width_r <= 2'h0;
			evsel_r <= 2'h0;
			evcnt_r <= `PCTC_RST_32;
			rld0_r <= `PCTC_RST_32;
			rld1_r <= `PCTC_RST_32;
		end else begin
			if (w_tc & be0) begin
				tc_r <= avs_writedata[7:0] & 8'hB9; // Status bits read-only
			end
			if (w_sp & be0) begin
				sp_r <= avs_writedata[7:0] & 8'hCF;
			end
			if (w_cc & be0) begin
				width_r <= avs_writedata[`PCTC_CC_WID_HI:`PCTC_CC_WID_LO];
			end
			if (w_cc & be1) begin
				evsel_r <= avs_writedata[`PCTC_CC_EVSEL_HI:`PCTC_CC_EVSEL_LO];
			end
			if (w_ev) begin
				evcnt_r <= be_merge(evcnt_r, avs_writedata, avs_byteenable);
			end
			if (w_r0) begin
				rld0_r <= be_merge(rld0_r, avs_writedata, avs_byteenable);
			end
			if (w_r1) begin
				rld1_r <= be_merge(rld1_r, avs_writedata, avs_byteenable);
			end
		end
	end

	// Capture enable: software set, hardware clears on the last event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cap_en_r <= 1'b0;
		end else if (w_cc & be0 & avs_writedata[`PCTC_CC_EN]) begin
			cap_en_r <= 1'b1;
		end else if ((w_cc & be0) | (cap_evt & last_evt) | st_clr) begin
			cap_en_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path
	wire [7:0] tc_rd = {tc_r[7], 1'b0, tc_r[5:3], act, buf_nempty,
		tc_r[0]};
	wire [31:0] cc_rd = {22'h0, evsel_r, width_r, 5'h0, cap_en_r};
	logic [31:0] rd_mux;
	always_comb begin
		case (avs_address)
			`PCTC_OFS_TRMCTL: rd_mux = {24'h0, tc_rd};
			`PCTC_OFS_SPMOD: rd_mux = {24'h0, sp_r};
			`PCTC_OFS_CAPCTL: rd_mux = cc_rd;
			`PCTC_OFS_EVCNT: rd_mux = evcnt_r;
			`PCTC_OFS_RLD0: rd_mux = rld0_r;
			`PCTC_OFS_RLD1: rd_mux = rld1_r;
			`PCTC_OFS_ADR0: rd_mux = adr0_r;
			`PCTC_OFS_ADR1: rd_mux = adr1_r;
			`PCTC_OFS_TRCNT: rd_mux = trcnt_r;
			default: rd_mux = 32'h0; // Unmapped reads zero
		endcase
	end

	// Read data captured in the wait cycle, stands at the answer edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read & ~ack_r) begin
			avs_readdata <= rd_mux;
		end
	end
endmodule

/* File: dv/pctc_top_properties.sv */
// Port checks of the capture transfer control block, bound below.
// Assumes the byte map of pctc_defines.svh and a 25 MHz clk.
`timescale 1ns/1ps
`include "pctc_defines.svh"
module pctc_top_properties #(parameter int QUIET = 32) (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset
	input wire logic [7:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest, // Stall
	input wire pctc_pkg::pctc_ramwr_s ram_wr, // RAM address and data
	input wire logic ram_valid, // RAM request
	input wire logic ram_ready // RAM accept
);
	////////////////////////////////////////
	logic [7:0] ctl_r; // Shadow of transfer_control
	logic [7:0] quiet_r; // Cycles with soft reset low
	wire rd_ack = avs_read && !avs_waitrequest; // Read answered
	wire ctl_wr = avs_write && !avs_waitrequest && avs_byteenable[0] &&
		avs_address == `PCTC_OFS_TRMCTL; // Control write lands
	// Alternation moves addresses on its own, so steps are not judged then
	wire no_alt = ctl_r[5:4] != 2'h2;
	wire [7:0] quiet_nxt = (ctl_wr || ctl_r[0]) ? 8'h00 :
		quiet_r + {7'h00, quiet_r != 8'hFF};
	// Shadow and quiet counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl_r <= 8'h00;
			quiet_r <= 8'h00;
		end else begin
			ctl_r <= ctl_wr ? avs_writedata[7:0] : ctl_r;
			quiet_r <= quiet_nxt;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Head word waiting for the RAM
	sequence s_stall;
		ram_valid && !ram_ready && !avs_write && no_alt;
	endsequence
	// Word accepted, then a quiet bus cycle; a counter write or reload
	// just before would move the baseline, so those cycles are skipped
	sequence s_pop;
		ram_valid && ram_ready && !avs_write && !$past(avs_write) &&
		!$past(avs_write, 2) && no_alt ##1 !avs_write;
	endsequence
	////////////////////////////////////////
	chk_wait_once: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held past one cycle");
	chk_idle_ready: assert property (!avs_read && !avs_write |->
		!avs_waitrequest)
		else $error("waitrequest without a request");
	chk_unmapped_zero: assert property (rd_ack &&
		avs_address > `PCTC_OFS_TRCNT |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_ctl_readback: assert property (
		rd_ack && avs_address == `PCTC_OFS_TRMCTL |->
		{avs_readdata[7], avs_readdata[5:3], avs_readdata[0]} ==
		{ctl_r[7], ctl_r[5:3], ctl_r[0]})
		else $error("control bits read back wrong");
	chk_stall_hold: assert property (
		s_stall ##1 s_stall ##1 ram_valid |-> $stable(ram_wr))
		else $error("waiting word changed");
	chk_step_four: assert property (
		s_pop |=> ram_wr.addr == $past(ram_wr.addr, 2) + 32'h4)
		else $error("address did not step by four");
	chk_quiet_valid: assert property (
		quiet_r >= 8'(QUIET) |-> !ram_valid)
		else $error("transfer while soft reset low");
	chk_quiet_status: assert property (
		rd_ack && avs_address == `PCTC_OFS_TRMCTL &&
		quiet_r >= 8'(QUIET) |-> !avs_readdata[1])
		else $error("buffer status set in soft reset");
endmodule
bind pctc_top pctc_top_properties i_pctc_top_properties (.clk, .rst,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest, .ram_wr, .ram_valid, .ram_ready);

/* File: dv/pctc_src.sv */
// Parallel data source: free running acquisition clock, one strobe.
// Assumes the capture event select points at strobe pin two.
`timescale 1ns/1ps
module pctc_src (
	output logic acquisition_clock, // Free running, 320 ns
	output logic [5:2] strobe_pins, // Only pin two pulses
	output logic [31:0] data_pins // Parallel data
);
	// Clock keeps running so init and sync logic always see edges
	initial begin
		acquisition_clock = 1'b0;
		strobe_pins = 4'h0;
		data_pins = 32'h0;
		forever #160 acquisition_clock = ~acquisition_clock;
	end
	// One item over one tick; slow adds an idle period
	task automatic put(input logic [31:0] d, input logic slow);
		@(negedge acquisition_clock);
		data_pins = d;
		strobe_pins[2] = 1'b1;
		@(negedge acquisition_clock);
		strobe_pins[2] = 1'b0;
		data_pins = ~d; // Released: never the old value
		if (slow) begin
			@(negedge acquisition_clock);
		end
	endtask
endmodule

/* File: dv/parallel_capture_transfer_ctrl_tb.sv */
// Self-checking bench of the capture transfer control block.
// Assumes pctc_src drives the pins and this bench plays the RAM.
`timescale 1ns/1ps
`include "pctc_defines.svh"
module parallel_capture_transfer_ctrl_tb;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, ram_valid;
	logic ram_ready, acquisition_clock, first_control_pin, dec4_underflow;
	logic stall, v_seen; // RAM hold-off and valid seen
	logic [7:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [5:2] strobe_pins;
	logic [31:0] avs_writedata, avs_readdata, data_pins, q, rnd, rdy_s;
	logic [31:0] nxt_addr; // Expected active counter
	pctc_pkg::pctc_ramwr_s ram_wr;
	logic [63:0] got[$], exp[$]; // Accepted and expected words
	int bad_count, checked;
	pctc_top i_pctc_top (.clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.acquisition_clock, .first_control_pin, .strobe_pins, .data_pins,
		.dec4_underflow, .ram_wr, .ram_valid, .ram_ready);
	pctc_src i_pctc_src (.acquisition_clock, .strobe_pins, .data_pins);
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] lane_mask(input logic [1:0] w);
		return w == 2'h2 ? 32'hFFFFFFFF : w == 2'h1 ? 32'h0000FFFF : 32'hFF;
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		checked++;
		if (seen !== want) begin
			bad_count++;
			$display("Error at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// Sampled at the rising edge, before that edge's updates land
		do begin
			@(posedge clk);
			n++;
			done = avs_waitrequest === 1'b0;
		end while (!done && n < 100);
		r = avs_readdata;
		check(done, 1'b1);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge acquisition_clock);
		repeat (4) @(posedge clk);
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (got.size() < exp.size() && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check(got.size(), exp.size());
		while (got.size() > 0 && exp.size() > 0) begin
			check(got.pop_front(), exp.pop_front());
		end
	endtask
	// Set up, send n items of width w, predict words and addresses
	task automatic run(input logic [1:0] w, input int n, input logic rl,
		input logic hold);
		logic [31:0] d, acc, base, r;
		int k, words;
		acc = 32'h0;
		k = 0;
		words = 0;
		rnd = lfsr(rnd);
		base = rnd & 32'h0000FFF0;
		wr(`PCTC_OFS_TRMCTL, {28'h0, rl, 3'h0});
		ticks(5);
		wr(`PCTC_OFS_RLD0, base); // Ignored in continuous mode
		if (rl) begin
			wr(`PCTC_OFS_ADR0, base ^ 32'h00000100);
			nxt_addr = base;
		end
		wr(`PCTC_OFS_TRMCTL, {28'h0, rl, 3'h1});
		ticks(6);
		wr(`PCTC_OFS_EVCNT, hold ? 32'h0 : 32'(n));
		wr(`PCTC_OFS_CAPCTL, {24'h0, w, 6'h01});
		for (int i = 0; i < n; i++) begin
			rnd = lfsr(rnd);
			d = rnd & lane_mask(w);
			i_pctc_src.put(rnd, rnd[9]);
			acc = acc | (d << (k * (8 << w)));
			k++;
			// Word full, or last counted item flushes with zero pad
			if (k == (4 >> w) || i == n - 1) begin
				exp.push_back({nxt_addr, acc});
				nxt_addr = nxt_addr + 32'h4;
				acc = 32'h0;
				k = 0;
				words++;
			end
		end
		ticks(3);
		if (!hold) begin
			drain();
			rd(`PCTC_OFS_TRCNT, r);
			check(r, words);
			rd(`PCTC_OFS_TRMCTL, r);
			check(r[7:0], {4'h0, rl, 3'h1});
		end
	endtask
	task automatic conclude();
		$display("Counts: checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// RAM side: record accepts, ready pulses after valid was seen
	always @(negedge clk) begin
		v_seen <= ram_valid;
		if (ram_valid === 1'b1 && ram_ready === 1'b1) begin
			got.push_back(ram_wr);
		end
	end
	always @(posedge clk) begin
		rdy_s <= lfsr(rdy_s);
		ram_ready <= v_seen && !ram_ready && !stall && rdy_s[3];
	end
	initial begin
		#1000000;
		bad_count++;
		$display("Error at %0t: watchdog expired", $time);
		conclude();
	end
	initial begin
		rst = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		first_control_pin = 1'b0;
		dec4_underflow = 1'b0;
		ram_ready = 1'b0;
		stall = 1'b0;
		v_seen = 1'b0;
		rnd = 32'hF3E0;
		rdy_s = 32'hF3E0;
		nxt_addr = 32'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 3; i++) begin
			rd(8'(4 * i), q);
			check(q, 32'h0);
		end
		wr(`PCTC_OFS_TRMCTL, 32'h00000006);
		rd(`PCTC_OFS_TRMCTL, q);
		check(q, 32'h0);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, q);
		check(q, 32'h0);
		$display("Test registers done");
		run(2'h0, 4, 1'b0, 1'b0);
		run(2'h1, 3, 1'b0, 1'b0);
		run(2'h2, 2, 1'b0, 1'b0);
		$display("Test widths done");
		// Two words stuck behind a stalled RAM, then soft reset
		stall <= 1'b1;
		run(2'h0, 8, 1'b0, 1'b1);
		@(negedge clk);
		check(ram_valid, 1'b1);
		@(posedge clk);
		rd(`PCTC_OFS_TRMCTL, q);
		check(q[1], 1'b1);
		wr(`PCTC_OFS_TRMCTL, 32'h0);
		ticks(2);
		rd(`PCTC_OFS_TRMCTL, q);
		check(q[7:0], 8'h00);
		rd(`PCTC_OFS_TRCNT, q);
		check(q, 32'h0);
		i_pctc_src.put(32'h000000A5, 1'b0);
		ticks(3);
		@(negedge clk);
		check(ram_valid, 1'b0);
		@(posedge clk);
		wr(`PCTC_OFS_CAPCTL, 32'h0);
		stall <= 1'b0;
		repeat (20) @(posedge clk);
		check(got.size(), 0);
		exp.delete();
		$display("Test soft reset done");
		run(2'h0, 5, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			run(rnd[1:0] == 2'h3 ? 2'h1 : rnd[1:0],
				1 + int'(rnd[5:2]) % 9, rnd[6], 1'b0);
		end
		$display("Test random runs done");
		// Special mode: 16-bit items in 16-bit lanes, pin two as clock
		wr(`PCTC_OFS_TRMCTL, 32'h8);
		ticks(5);
		wr(`PCTC_OFS_SPMOD, 32'h8F);
		wr(`PCTC_OFS_RLD0, 32'h300);
		wr(`PCTC_OFS_TRMCTL, 32'h9);
		ticks(6);
		wr(`PCTC_OFS_EVCNT, 32'h0);
		wr(`PCTC_OFS_CAPCTL, 32'h41);
		// One event per two falling edges: eight items, two words
		repeat (8) i_pctc_src.put(32'h0000C35A, 1'b0);
		exp.push_back({32'h300, 32'hC35AC35A});
		exp.push_back({32'h304, 32'hC35AC35A});
		ticks(3);
		drain();
		// Init level held past the delayed method's four periods
		first_control_pin <= 1'b1;
		ticks(6);
		repeat (4) i_pctc_src.put(32'h0000C35A, 1'b0);
		ticks(3);
		check(got.size(), 0);
		rd(`PCTC_OFS_TRCNT, q);
		check(q, 32'h2);
		$display("Test special mode done");
		// Alternation switched by the decimation pulse
		wr(`PCTC_OFS_TRMCTL, 32'hA0);
		ticks(5);
		wr(`PCTC_OFS_TRMCTL, 32'hA1);
		ticks(6);
		dec4_underflow <= 1'b1;
		@(posedge clk);
		dec4_underflow <= 1'b0;
		rd(`PCTC_OFS_TRMCTL, q);
		check(q[7:0], 8'hA5);
		wr(`PCTC_OFS_TRMCTL, 32'hA0);
		ticks(2);
		rd(`PCTC_OFS_TRMCTL, q);
		check(q[7:0], 8'hA0);
		$display("Test alternation done");
		conclude();
	end
endmodule
